// *** adcc0_pkg.sv ***
package adcc0_pkg;

  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_THRESH_FILT = 6'h08;
  localparam logic [5:0] IDX_CH0_CONFIG  = 6'h09;
  localparam logic [5:0] IDX_OFS_HIGH    = 6'h0A;
  localparam logic [5:0] IDX_OFS_LOW     = 6'h0B;
  localparam logic [5:0] IDX_GAIN_HIGH   = 6'h0C;
  localparam logic [5:0] IDX_GAIN_LOW    = 6'h0D;

  // Field positions
  localparam int THR_LOW_LSB   = 8;
  localparam int COEF_LSB      = 0;
  localparam int PHASE_LSB     = 6;
  localparam int DC_OFF_BIT    = 2;
  localparam int INSEL_LSB     = 0;
  localparam int TRIM_LOW_LSB  = 8;
  localparam int TRIM_HIGH_LSB = 8;

  // Reset values
  localparam logic [7:0]  RST_THR_LOW   = 8'h00;
  localparam logic [3:0]  RST_COEF      = 4'h0;
  localparam logic [9:0]  RST_PHASE     = 10'h000;
  localparam logic        RST_DC_OFF    = 1'h0;
  localparam logic [1:0]  RST_INSEL     = 2'h0;
  localparam logic [15:0] RST_OFS_HIGH  = 16'h0000;
  localparam logic [7:0]  RST_OFS_LOW   = 8'h00;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [7:0]  RST_GAIN_LOW  = 8'h00;

  // Input selector codes
  localparam logic [1:0] INSEL_PINS     = 2'h0;
  localparam logic [1:0] INSEL_SHORTED  = 2'h1;
  localparam logic [1:0] INSEL_TEST_POS = 2'h2;
  localparam logic [1:0] INSEL_TEST_NEG = 2'h3;

  localparam logic [3:0] COEF_FILTER_OFF = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE = 2'h1,
    ADCC_ST_RESP = 2'h2
  } adcc_state_t;

  typedef struct packed {
    logic signed [9:0] phaseDelay;
    logic              dcRemovalOff;
    logic [1:0]        inputSelect;
  } adcc_ch0_config_t;

  typedef struct packed {
    logic [23:0] offsetTrim;
    logic [23:0] gainTrim;
  } adcc_trim_t;

endpackage

// *** adcc0_regs.sv ***
`timescale 1ns/10ps

// Summary of operation
// - Coefficient zero off; codes 1-15 halve from 1/4
// - Shared register upper byte holds threshold low byte
// - Ten-bit signed phase delay in bits 15:6
// - Override bit bypasses channel-0 filter regardless
// - Selector picks pins, shorted, positive or negative test
// - Offset trim 24 bits split high/low, reset zero
// - Gain trim split likewise, high resets 8000h
// - Low registers' lower byte reads zero, read-only
module adcc0_regs
  import adcc0_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    clkEn,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [AXI_DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [AXI_DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Settings towards the conversion path
  output adcc_ch0_config_t                ch0Cfg,
  output adcc_trim_t                   ch0Trim,
  output logic [7:0]                   detectThresholdLowByte,
  output logic [3:0]                   dcRemovalCoefficient,
  output logic [4:0]                   dcCoefShift,
  output logic                         ch0DcFilterOn,
  output logic [3:0]                   ch0InputOneHot
);

  // Register state
  logic [7:0]        thrLow_r;
  logic [3:0]        coef_r;
  logic [9:0]        phase_r;
  logic              dcOff_r;
  logic [1:0]        inSel_r;
  logic [15:0]       ofsHigh_r;
  logic [7:0]        ofsLow_r;
  logic [15:0]       gainHigh_r;
  logic [7:0]        gainLow_r;

  // Write channel state
  adcc_state_t       wState_r;
  logic              awHeld_r;
  logic              wHeld_r;
  logic [5:0]        wIdx_r;
  logic              wHit_r;
  logic [15:0]       wData_r;
  logic [1:0]        wStrb_r;
  logic              doWrite;
  logic [15:0]       wMerged;

  // Read channel state
  adcc_state_t       rState_r;
  logic [15:0]       rdWord;
  logic              rdHit;

  // True when the address is word aligned and names a mapped register
  function automatic logic addrHit(input logic [AXI_ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[AXI_ADDR_W-1:2];
    addrHit = (addr[1:0] == 2'h0) &&
              (idx >= IDX_THRESH_FILT) && (idx <= IDX_GAIN_LOW);
  endfunction

  function automatic logic [5:0] addrIdx(input logic [AXI_ADDR_W-1:0] addr);
    addrIdx = addr[AXI_ADDR_W-1:2];
  endfunction

  // Byte-lane merge of the held write data into a 16-bit register image
  function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [1:0]  strb);
    laneMerge = old;
    if (strb[0]) begin
      laneMerge[7:0] = data[7:0];
    end
    if (strb[1]) begin
      laneMerge[15:8] = data[15:8];
    end
  endfunction

  // ---------------- Write address / data capture ----------------
  // Readies fall with the clock enable, so no handshake completes while frozen
  assign s_axi_awready = clkEn && (wState_r == ADCC_ST_IDLE) && !awHeld_r;
  assign s_axi_wready  = clkEn && (wState_r == ADCC_ST_IDLE) && !wHeld_r;
  assign doWrite       = (wState_r == ADCC_ST_IDLE) && awHeld_r && wHeld_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      wIdx_r   <= 6'h00;
      wHit_r   <= 1'b0;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        wIdx_r   <= addrIdx(s_axi_awaddr);
        wHit_r   <= addrHit(s_axi_awaddr);
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wHeld_r <= 1'b0;
      wData_r <= 16'h0000;
      wStrb_r <= 2'h0;
    end else if (clkEn) begin
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata[15:0];
        wStrb_r <= s_axi_wstrb[1:0];
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // ---------------- Write response ----------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wState_r     <= ADCC_ST_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clkEn) begin
      case (wState_r)
        ADCC_ST_IDLE: begin
          if (doWrite) begin
            wState_r     <= ADCC_ST_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wHit_r ? RESP_OKAY : RESP_SLVERR;
          end
        end
        ADCC_ST_RESP: begin
          if (s_axi_bready) begin
            wState_r     <= ADCC_ST_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wState_r     <= ADCC_ST_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Reserved bits of the image are ignored, so stray host writes cannot stick.
  // A process rather than an assign, so the register reads inside rdImage wake it
  always_comb begin
    wMerged = laneMerge(rdImage(wIdx_r), wData_r, wStrb_r);
  end

  // ---------------- Register updates ----------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      thrLow_r <= RST_THR_LOW;
      coef_r   <= RST_COEF;
    end else if (clkEn && doWrite && wHit_r && wIdx_r == IDX_THRESH_FILT) begin
      thrLow_r <= wMerged[THR_LOW_LSB +: 8];
      coef_r   <= wMerged[COEF_LSB +: 4];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      phase_r <= RST_PHASE;
      dcOff_r <= RST_DC_OFF;
      inSel_r <= RST_INSEL;
    end else if (clkEn && doWrite && wHit_r && wIdx_r == IDX_CH0_CONFIG) begin
      phase_r <= wMerged[PHASE_LSB +: 10];
      dcOff_r <= wMerged[DC_OFF_BIT];
      inSel_r <= wMerged[INSEL_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ofsHigh_r <= RST_OFS_HIGH;
      ofsLow_r  <= RST_OFS_LOW;
    end else if (clkEn && doWrite && wHit_r) begin
      if (wIdx_r == IDX_OFS_HIGH) begin
        ofsHigh_r <= wMerged;
      end
      if (wIdx_r == IDX_OFS_LOW) begin
        ofsLow_r <= wMerged[TRIM_LOW_LSB +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gainHigh_r <= RST_GAIN_HIGH;
      gainLow_r  <= RST_GAIN_LOW;
    end else if (clkEn && doWrite && wHit_r) begin
      if (wIdx_r == IDX_GAIN_HIGH) begin
        gainHigh_r <= wMerged;
      end
      if (wIdx_r == IDX_GAIN_LOW) begin
        gainLow_r <= wMerged[TRIM_LOW_LSB +: 8];
      end
    end
  end

  // ---------------- Read image ----------------
  // Shared by the read path and the byte-lane merge of writes
  function automatic logic [15:0] rdImage(input logic [5:0] idx);
    rdImage = 16'h0000;
    case (idx)
      IDX_THRESH_FILT: begin
        rdImage[THR_LOW_LSB +: 8] = thrLow_r;
        rdImage[COEF_LSB +: 4]    = coef_r;
      end
      IDX_CH0_CONFIG: begin
        rdImage[PHASE_LSB +: 10] = phase_r;
        rdImage[DC_OFF_BIT]      = dcOff_r;
        rdImage[INSEL_LSB +: 2]  = inSel_r;
      end
      IDX_OFS_HIGH:  rdImage = ofsHigh_r;
      IDX_OFS_LOW:   rdImage[TRIM_LOW_LSB +: 8] = ofsLow_r;
      IDX_GAIN_HIGH: rdImage = gainHigh_r;
      IDX_GAIN_LOW:  rdImage[TRIM_LOW_LSB +: 8] = gainLow_r;
      default:       rdImage = 16'h0000;
    endcase
  endfunction

  // Same reason as the write merge: a repeated read of one address must see new contents
  always_comb begin
    rdHit  = addrHit(s_axi_araddr);
    rdWord = rdImage(addrIdx(s_axi_araddr));
  end
  assign s_axi_arready = clkEn && (rState_r == ADCC_ST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rState_r     <= ADCC_ST_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clkEn) begin
      case (rState_r)
        ADCC_ST_IDLE: begin
          if (s_axi_arvalid) begin
            rState_r     <= ADCC_ST_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rdHit ? rdWord : 16'h0000};
            s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        ADCC_ST_RESP: begin
          if (s_axi_rready) begin
            rState_r     <= ADCC_ST_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rState_r     <= ADCC_ST_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- Settings towards the conversion path ----------------
  assign ch0Cfg.phaseDelay    = signed'(phase_r);
  assign ch0Cfg.dcRemovalOff  = dcOff_r;
  assign ch0Cfg.inputSelect   = inSel_r;
  assign ch0Trim.offsetTrim   = {ofsHigh_r, ofsLow_r};
  assign ch0Trim.gainTrim     = {gainHigh_r, gainLow_r};
  assign detectThresholdLowByte = thrLow_r;
  assign dcRemovalCoefficient   = coef_r;

  // Coefficient is 2^-(code+1); shift is zero while the coefficient code is zero
  assign dcCoefShift = (coef_r == COEF_FILTER_OFF) ? 5'h00 : ({1'b0, coef_r} + 5'h01);

  // The per-channel override wins over any global coefficient
  assign ch0DcFilterOn = (coef_r != COEF_FILTER_OFF) && !dcOff_r;

  // One-hot input routing: pins, shorted, positive test, negative test
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gInSel
      assign ch0InputOneHot[gi] = (inSel_r == 2'(gi));
    end
  endgenerate

endmodule // adcc0_regs

// *** adcc0_regs_chk.sv ***
`timescale 1ns/10ps
module adcc0_regs_chk
  import adcc0_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic                  s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire adcc_ch0_config_t         ch0Cfg,
  input wire adcc_trim_t            ch0Trim,
  input wire logic [3:0]            dcRemovalCoefficient,
  input wire logic [4:0]            dcCoefShift,
  input wire logic                  ch0DcFilterOn,
  input wire logic [3:0]            ch0InputOneHot
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_shift; dcCoefShift == ((dcRemovalCoefficient == 4'h0) ? 5'h00 : 5'(dcRemovalCoefficient) + 5'h01); endproperty
  a_shift: assert property (p_shift)
    else $error("coefficient shift wrong");
  property p_gate; ch0DcFilterOn == (dcRemovalCoefficient != 4'h0 && !ch0Cfg.dcRemovalOff); endproperty
  a_gate: assert property (p_gate)
    else $error("filter enable wrong");
  property p_sel; ch0InputOneHot == (4'h1 << ch0Cfg.inputSelect); endproperty
  a_sel: assert property (p_sel)
    else $error("input select decode wrong");
  property p_rst_trim; $rose(rst_b) |-> ch0Trim == 48'h0000_0080_0000; endproperty
  a_rst_trim: assert property (p_rst_trim)
    else $error("trim reset value wrong");
  property p_rst_cfg; $rose(rst_b) |-> ch0Cfg == 13'h0000 && dcRemovalCoefficient == 4'h0; endproperty
  a_rst_cfg: assert property (p_rst_cfg)
    else $error("config reset value wrong");
  property p_commit; $past(rst_b) && $changed({ch0Cfg, ch0Trim, dcRemovalCoefficient}) |-> $rose(s_axi_bvalid); endproperty
  a_commit: assert property (p_commit)
    else $error("settings changed without a write");
  property p_bhold; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response not released after its handshake");
  property p_rhold; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_rhold: assert property (p_rhold)
    else $error("read response not released after its handshake");
  property p_arbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arbusy: assert property (p_arbusy)
    else $error("read accepted while busy");
  c_write: cover property ($rose(s_axi_bvalid));
  c_read: cover property ($rose(s_axi_rvalid));
  c_bypass: cover property (dcRemovalCoefficient != 4'h0 && ch0Cfg.dcRemovalOff);
endmodule // adcc0_regs_chk

// *** tb_adcc0_regs.sv ***
`timescale 1ns/10ps
module tb_adcc0_regs
  import adcc0_pkg::*;
;
  logic          sys_clk, rst_b, clkEn, ta, tw, tr;
  logic [7:0]    s_axi_awaddr, s_axi_araddr, detectThresholdLowByte;
  logic [31:0]   s_axi_wdata, s_axi_rdata;
  logic [3:0]    s_axi_wstrb, dcRemovalCoefficient, ch0InputOneHot;
  logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ch0DcFilterOn;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [4:0]    dcCoefShift;
  adcc_ch0_config_t ch0Cfg;
  adcc_trim_t    ch0Trim;
  int            n_mismatch, cmp_count, cyc, c;
  adcc0_regs adcc0_regs_inst (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ch0Cfg(ch0Cfg), .ch0Trim(ch0Trim), .detectThresholdLowByte(detectThresholdLowByte),
    .dcRemovalCoefficient(dcRemovalCoefficient), .dcCoefShift(dcCoefShift), .ch0DcFilterOn(ch0DcFilterOn),
    .ch0InputOneHot(ch0InputOneHot));
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Ready rises with the request and waits for valid; an idle edge after each transfer keeps drives apart
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= {2'h0, s};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_bvalid & s_axi_bready;
      if (tr) chk("bresp", 32'(s_axi_bresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_bready <= 1'b0;
    end while (!tr);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      if (tr) chk(nm, s_axi_rdata, {16'h0000, ed});
      if (tr) chk("rresp", 32'(s_axi_rresp), 32'(er));
      @(posedge sys_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end while (!tr);
    @(posedge sys_clk);
  endtask
  task automatic t_reset();
    rd(8'h20, 16'h0000, RESP_OKAY, "thresh");
    rd(8'h24, 16'h0000, RESP_OKAY, "config");
    rd(8'h28, 16'h0000, RESP_OKAY, "ofsHigh");
    rd(8'h2C, 16'h0000, RESP_OKAY, "ofsLow");
    rd(8'h30, 16'h8000, RESP_OKAY, "gainHigh");
    rd(8'h34, 16'h0000, RESP_OKAY, "gainLow");
    $display("test reset done");
  endtask
  task automatic t_filter();
    wr(8'h20, 16'hA507, 2'h3, RESP_OKAY);
    rd(8'h20, 16'hA507, RESP_OKAY, "thresh");
    for (c = 0; c < 16; c++) begin
      wr(8'h20, {12'hA50, 4'(c)}, 2'h1, RESP_OKAY);
      @(negedge sys_clk);
      chk("shift", 32'(dcCoefShift), (c == 0) ? 32'(0) : 32'(c + 1));
      chk("filterOn", 32'(ch0DcFilterOn), 32'(c != 0));
      chk("coef", 32'(dcRemovalCoefficient), 32'(c));
      chk("thrByte", 32'(detectThresholdLowByte), 32'h0000_00A5);
      @(posedge sys_clk);
    end
    rd(8'h20, 16'hA50F, RESP_OKAY, "thresh");
    $display("test filter done");
  endtask
  task automatic t_config();
    wr(8'h24, 16'hFFC7, 2'h3, RESP_OKAY);
    rd(8'h24, 16'hFFC7, RESP_OKAY, "config");
    @(negedge sys_clk);
    chk("phase", 32'(ch0Cfg.phaseDelay), ~32'(0));
    chk("filterOn", 32'(ch0DcFilterOn), 32'(0));
    chk("dcOff", 32'(ch0Cfg.dcRemovalOff), 32'(1));
    @(posedge sys_clk);
    for (c = 0; c < 4; c++) begin
      wr(8'h24, 16'(c), 2'h1, RESP_OKAY);
      @(negedge sys_clk);
      chk("inputSel", 32'(ch0InputOneHot), 32'(1 << c));
      chk("inSelField", 32'(ch0Cfg.inputSelect), 32'(c));
      chk("filterOn", 32'(ch0DcFilterOn), 32'(1));
      @(posedge sys_clk);
    end
    $display("test config done");
  endtask
  task automatic t_trim();
    wr(8'h28, 16'h1234, 2'h3, RESP_OKAY);
    wr(8'h2C, 16'hABCD, 2'h3, RESP_OKAY);
    rd(8'h2C, 16'hAB00, RESP_OKAY, "ofsLow");
    wr(8'h30, 16'hFFFF, 2'h1, RESP_OKAY);
    rd(8'h30, 16'h80FF, RESP_OKAY, "gainHigh");
    wr(8'h34, 16'h5A77, 2'h2, RESP_OKAY);
    rd(8'h34, 16'h5A00, RESP_OKAY, "gainLow");
    @(negedge sys_clk);
    chk("ofsTrim", 32'(ch0Trim.offsetTrim), 32'h0012_34AB);
    chk("gainTrim", 32'(ch0Trim.gainTrim), 32'h0080_FF5A);
    @(posedge sys_clk);
    $display("test trim done");
  endtask
  task automatic t_bad();
    wr(8'h38, 16'h1111, 2'h3, RESP_SLVERR);
    wr(8'h21, 16'h1111, 2'h3, RESP_SLVERR);
    rd(8'h3C, 16'h0000, RESP_SLVERR, "unmapped");
    rd(8'h20, 16'hA50F, RESP_OKAY, "thresh");
    clkEn <= 1'b0;
    @(negedge sys_clk);
    chk("awreadyFrozen", 32'(s_axi_awready), 32'(0));
    chk("arreadyFrozen", 32'(s_axi_arready), 32'(0));
    @(posedge sys_clk);
    clkEn <= 1'b1;
    rst_b <= 1'b0;
    @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(8'h30, 16'h8000, RESP_OKAY, "gainHigh");
    rd(8'h24, 16'h0000, RESP_OKAY, "config");
    $display("test errors and reset done");
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    {sys_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    clkEn = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_filter();
    t_config();
    t_trim();
    t_bad();
    results();
  end
endmodule // tb_adcc0_regs
bind adcc0_regs adcc0_regs_chk adcc0_regs_chk_inst (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .ch0Cfg(ch0Cfg), .ch0Trim(ch0Trim),
  .dcRemovalCoefficient(dcRemovalCoefficient), .dcCoefShift(dcCoefShift), .ch0DcFilterOn(ch0DcFilterOn),
  .ch0InputOneHot(ch0InputOneHot));
